//--- asp_pkg.sv
// Shared constants and types for the serial result port.
// Assumes a single core clock and AXI4-Lite register access.
package asp_pkg;
  localparam int ASP_WORD_W = 18;
  localparam int ASP_CNT_W = 9;
  localparam int ASP_HALF_W = 8;
  localparam int ASP_SYNC_W = 10;
  localparam int ASP_PAR_LSB = 4;
  localparam int ASP_PAR_W = 6;
  localparam int ASP_FIFO_DEPTH = 8;
  // Time constants: master half period at the fastest divide setting
  localparam int ASP_CLK_NS = 10;
  localparam int ASP_HALF_NS = 20;
  localparam logic [ASP_HALF_W-1:0] ASP_HALF_BASE = ASP_HALF_W'(ASP_HALF_NS / ASP_CLK_NS);
  localparam logic [1:0] ASP_MODE_SERIAL = 2'h3;
  localparam logic [1:0] ASP_MODE_BYTE = 2'h2;
  localparam logic [1:0] ASP_MODE_WORD16 = 2'h1;
  localparam logic [1:0] ASP_MODE_WORD18 = 2'h0;
  // Register byte addresses
  localparam logic [3:0] ASP_ADDR_CTRL = 4'h0;
  localparam logic [3:0] ASP_ADDR_STATUS = 4'h4;
  localparam logic [3:0] ASP_ADDR_LAST = 4'h8;
  localparam int ASP_ADDR_W = 4;
  // CTRL fields
  localparam int ASP_CTRL_EN_BIT = 0;
  localparam int ASP_CTRL_CHAIN_LSB = 4;
  localparam int ASP_CHAIN_W = 4;
  localparam logic [31:0] ASP_CTRL_RESET = 32'h0000_0001;
  // STATUS fields
  localparam int ASP_ST_SERIAL_BIT = 0;
  localparam int ASP_ST_ACTIVE_BIT = 1;
  localparam int ASP_ST_MASTER_BIT = 2;
  localparam int ASP_ST_LEVEL_LSB = 4;
  localparam logic [1:0] ASP_RESP_OKAY = 2'h0;
  localparam logic [1:0] ASP_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic chain_rdc;
    logic clk_inv;
    logic sync_pol;
    logic ext_clk;
    logic [1:0] div_sel;
  } asp_cfg_type;

  typedef enum logic [1:0] {ST_IDLE, ST_MASTER, ST_SLAVE} asp_state_type;
endpackage : asp_pkg

//--- asp_fifo.sv
// Result FIFO between conversion source and serial shifter.
// Assumes source and sink share core_clk; ready is registered, valid is decoded from the registered count.
`timescale 1ns/1ps
`default_nettype none
module asp_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q, cnt_d;
  logic ready_q;
  wire push = in_valid & ready_q;
  wire pop = out_ready & (cnt_q != '0);
  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  // Ready comes straight from a flop so the top output stays registered
  assign in_ready = ready_q;
  assign out_data = mem_q[rd_q];
  assign out_valid = (cnt_q != '0);
  assign level = cnt_q;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b0;
    end else begin
      wr_q <= push ? AW'((wr_q + 1'b1) % DEPTH) : wr_q;
      rd_q <= pop ? AW'((rd_q + 1'b1) % DEPTH) : rd_q;
      cnt_q <= cnt_d;
      ready_q <= (cnt_d != (AW+1)'(DEPTH));
    end
  end
endmodule : asp_fifo
`default_nettype wire

//--- asp_serial_port.sv
// Serial result port with dual role configuration pins and AXI4-Lite status.
// Assumes pins are asynchronous to core_clk; results arrive on core_clk.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - Divide pins: parallel bits 4-5 outside serial
// R2 - Divide select only in master read-after-convert
// R3 - Config pins: parallel bits 6-9 outside serial
// R4 - Clock select low: drive serial clock
// R5 - Clock select high: follow external clock
// R6 - Polarity input low gives active-high marker
// R7 - Clock inversion applies master and slave
// R8 - External clock: pin is chain input
// R9 - Chain data appears 18 clocks later
// R10 - Read-select high: shift during conversion
// R11 - Read-select low: shift after conversion
// R12 - Two select inputs choose interface mode
// R13 - Slave updates on rising, inverted swaps
// R14 - Marker active while master data valid
// R15 - MSB first, MSB inverted when coding low
// R16 - Host keeps configuration static during reads
module asp_serial_port
  import asp_pkg::*;
#(
  parameter int WORD_W = ASP_WORD_W,
  parameter int FIFO_DEPTH = ASP_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [WORD_W-1:0] result_data,
  input wire logic result_valid,
  output logic result_ready,
  input wire logic conv_busy,
  input wire logic interface_select_low,
  input wire logic interface_select_high,
  input wire logic output_coding_select,
  input wire logic [ASP_PAR_W-1:0] par_pin_i,
  output logic [ASP_PAR_W-1:0] par_pin_o,
  output logic [ASP_PAR_W-1:0] par_pin_oe,
  input wire logic sclk_pin_i,
  output logic sclk_pin_o,
  output logic sclk_pin_oe,
  output logic serial_result_out,
  output logic frame_marker,
  input wire logic [ASP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ASP_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;

  // Three-stage input synchronisers, change accepted when stages 2 and 3 agree
  logic [ASP_SYNC_W-1:0] raw_in, s1_q, s2_q, s3_q, filt_q;
  assign raw_in = {sclk_pin_i, par_pin_i, output_coding_select,
                   interface_select_high, interface_select_low};
  genvar gi;
  generate
    for (gi = 0; gi < ASP_SYNC_W; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (!nrst) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          filt_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= raw_in[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          filt_q[gi] <= (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : filt_q[gi];
        end
      end
    end
  endgenerate

  // R12 mode decode
  wire [1:0] mode_sel = filt_q[1:0];
  wire serial_mode = (mode_sel == ASP_MODE_SERIAL);
  wire coding_sel = filt_q[2];
  wire [ASP_PAR_W-1:0] pins_f = filt_q[ASP_PAR_W+2:3];
  wire sclk_f = filt_q[ASP_SYNC_W-1];
  asp_cfg_type cfg;
  // Struct order matches pin order: chain, invert, polarity, source, divide
  assign cfg = asp_cfg_type'(pins_f);

  // Registers
  logic [31:0] ctrl_q;
  logic [WORD_W-1:0] last_q;
  asp_state_type state_q;
  logic [LVL_W-1:0] fifo_level;
  wire port_en = ctrl_q[ASP_CTRL_EN_BIT];
  wire [ASP_CHAIN_W-1:0] chain_words = ctrl_q[ASP_CTRL_CHAIN_LSB +: ASP_CHAIN_W];

  // FIFO between conversion results and shifter
  logic [WORD_W-1:0] head;
  logic head_valid;
  logic pop;
  asp_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_data(result_data),
    .in_valid(result_valid),
    .in_ready(result_ready),
    .out_data(head),
    .out_valid(head_valid),
    .out_ready(pop),
    .level(fifo_level)
  );

  // Shifter state
  logic [WORD_W-1:0] shreg_q;
  logic [ASP_CNT_W-1:0] bitcnt_q;
  logic [ASP_HALF_W-1:0] half_q;
  logic mclk_q, sclk_prev_q, chain_q, sync_q, sclk_o_q, sclk_oe_q;
  logic [ASP_PAR_W-1:0] par_o_q, par_oe_q;
  logic [WORD_W-1:0] par_word_q;

  // R2 divide select honoured only in master read-after-convert
  wire [ASP_HALF_W-1:0] half_len = cfg.chain_rdc ? ASP_HALF_BASE :
                                   ASP_HALF_W'(ASP_HALF_BASE << cfg.div_sel);
  wire half_done = (half_q >= half_len - 1'b1);
  wire mclk_fall = (state_q == ST_MASTER) & half_done & mclk_q;
  // R13 update edge: rising when not inverted, falling when inverted
  wire upd_edge = ((sclk_f ^ cfg.clk_inv) & ~(sclk_prev_q ^ cfg.clk_inv));
  wire smp_edge = (~(sclk_f ^ cfg.clk_inv) & (sclk_prev_q ^ cfg.clk_inv));
  wire [ASP_CNT_W-1:0] slave_bits =
    ASP_CNT_W'(WORD_W) * (ASP_CNT_W'(chain_words) + 1'b1);
  // R10 read during conversion starts at once; R11 waits for conversion end
  wire master_go = serial_mode & port_en & ~cfg.ext_clk & head_valid &
                   (cfg.chain_rdc | ~conv_busy);
  wire slave_go = serial_mode & port_en & cfg.ext_clk & head_valid;
  wire load = (state_q == ST_IDLE) & (master_go | slave_go);
  // R15 MSB inverted for twos complement when coding select is low
  wire [WORD_W-1:0] coded = {head[WORD_W-1] ^ ~coding_sel, head[WORD_W-2:0]};
  wire par_pop = ~serial_mode & head_valid;
  assign pop = load | par_pop;
  wire master_end = mclk_fall & (bitcnt_q == ASP_CNT_W'(WORD_W - 1));
  wire slave_end = (state_q == ST_SLAVE) & upd_edge & (bitcnt_q == slave_bits - 1'b1);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (load) begin
            state_q <= cfg.ext_clk ? ST_SLAVE : ST_MASTER;
          end
        end
        ST_MASTER: begin
          if (master_end || !serial_mode) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          if (slave_end || !serial_mode) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      shreg_q <= '0;
      bitcnt_q <= '0;
      chain_q <= 1'b0;
    end else begin
      chain_q <= smp_edge ? pins_f[5] : chain_q;
      if (load) begin
        shreg_q <= coded;
        bitcnt_q <= '0;
      end else if (mclk_fall || (state_q == ST_SLAVE && upd_edge)) begin
        // R8 R9 chain bits enter behind the word, emerging 18 clocks later
        shreg_q <= {shreg_q[WORD_W-2:0], chain_q & (state_q == ST_SLAVE)};
        bitcnt_q <= bitcnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      half_q <= '0;
      mclk_q <= 1'b0;
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_f;
      half_q <= (state_q != ST_MASTER || half_done) ? '0 : half_q + 1'b1;
      mclk_q <= (state_q == ST_MASTER && !master_end) ? (mclk_q ^ half_done) : 1'b0;
    end
  end

  // R4 R5 drive the clock pin only as master; R7 inversion on the driven clock
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sclk_o_q <= 1'b0;
      sclk_oe_q <= 1'b0;
    end else begin
      sclk_oe_q <= serial_mode & ~cfg.ext_clk;
      sclk_o_q <= mclk_q ^ cfg.clk_inv;
    end
  end

  // R6 R14 marker at its active level for the whole master frame
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sync_q <= 1'b0;
    end else begin
      sync_q <= ((load && !cfg.ext_clk) ||
                 (state_q == ST_MASTER && !master_end)) ^ cfg.sync_pol;
    end
  end

  // R1 R3 parallel role outside serial mode, inputs inside it
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      par_o_q <= '0;
      par_oe_q <= '0;
      par_word_q <= '0;
    end else begin
      par_word_q <= par_pop ? head : par_word_q;
      par_o_q <= par_word_q[ASP_PAR_LSB +: ASP_PAR_W];
      par_oe_q <= {ASP_PAR_W{~serial_mode}};
    end
  end

  assign par_pin_o = par_o_q;
  assign par_pin_oe = par_oe_q;
  assign sclk_pin_o = sclk_o_q;
  assign sclk_pin_oe = sclk_oe_q;
  assign serial_result_out = shreg_q[WORD_W-1];
  assign frame_marker = sync_q;

  // AXI4-Lite slave: write taken when address and data are both present
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  wire wr_take = s_axi_awvalid & s_axi_wvalid & ~awready_q & ~bvalid_q;
  wire rd_take = s_axi_arvalid & ~arready_q & ~rvalid_q;
  wire wr_ctrl = (s_axi_awaddr == ASP_ADDR_CTRL);
  wire wr_ok = wr_ctrl || (s_axi_awaddr == ASP_ADDR_STATUS) || (s_axi_awaddr == ASP_ADDR_LAST);
  wire [31:0] status_word = {{(32 - ASP_ST_LEVEL_LSB - LVL_W){1'b0}}, fifo_level, 1'b0,
                             state_q == ST_MASTER, state_q != ST_IDLE, serial_mode};
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_word = '0;
    rd_ok = 1'b1;
    if (s_axi_araddr == ASP_ADDR_CTRL) begin
      rd_word = ctrl_q;
    end else if (s_axi_araddr == ASP_ADDR_STATUS) begin
      rd_word = status_word;
    end else if (s_axi_araddr == ASP_ADDR_LAST) begin
      rd_word = 32'(last_q);
    end else begin
      rd_ok = 1'b0;
    end
  end
  logic [31:0] strb_mask;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_strb
      assign strb_mask[gi*8 +: 8] = {8{s_axi_wstrb[gi]}};
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= ASP_RESP_OKAY;
      ctrl_q <= ASP_CTRL_RESET;
    end else begin
      awready_q <= wr_take;
      wready_q <= wr_take;
      bvalid_q <= wr_take | (bvalid_q & ~s_axi_bready);
      bresp_q <= wr_take ? (wr_ok ? ASP_RESP_OKAY : ASP_RESP_SLVERR) : bresp_q;
      if (wr_take && wr_ctrl) begin
        ctrl_q <= (ctrl_q & ~strb_mask) | (s_axi_wdata & strb_mask);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= ASP_RESP_OKAY;
      last_q <= '0;
    end else begin
      arready_q <= rd_take;
      rvalid_q <= rd_take | (rvalid_q & ~s_axi_rready);
      rdata_q <= rd_take ? rd_word : rdata_q;
      rresp_q <= rd_take ? (rd_ok ? ASP_RESP_OKAY : ASP_RESP_SLVERR) : rresp_q;
      last_q <= load ? coded : last_q;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_par_pins_drive: assert property (!serial_mode |=> par_oe_q == '1) // R1
    else $error("parallel pins not driven outside serial mode");
  a_par_pins_release: assert property (serial_mode |=> par_oe_q == '0) // R3
    else $error("parallel pins driven in serial mode");
  a_div_ignored: assert property (cfg.chain_rdc |-> half_len == ASP_HALF_BASE) // R2
    else $error("divide select used outside read after convert");
  a_master_clk_drive: assert property (state_q == ST_MASTER |=> sclk_oe_q) // R4
    else $error("master clock not driven");
  a_slave_clk_free: assert property (serial_mode && cfg.ext_clk |=> !sclk_oe_q) // R5
    else $error("clock pin driven with external clock");
  a_marker_level: assert property ($past(state_q) == ST_MASTER && state_q == ST_MASTER
    |-> sync_q == ~cfg.sync_pol) // R6
    else $error("marker not at active level during frame");
  a_clk_idle_invert: assert property (state_q == ST_IDLE ##1 state_q == ST_IDLE
    |=> sclk_o_q == $past(cfg.clk_inv)) // R7
    else $error("idle clock level ignores inversion");
  a_chain_insert: assert property (state_q == ST_SLAVE && upd_edge && !slave_end
    |=> shreg_q[0] == $past(chain_q)) // R9
    else $error("chain bit not inserted at update edge");
  a_rac_wait: assert property (load && !cfg.ext_clk && !cfg.chain_rdc |-> !conv_busy) // R11
    else $error("read after convert started during conversion");
  a_frame_end: assert property (master_end |=> state_q == ST_IDLE && sync_q == cfg.sync_pol) // R14
    else $error("frame marker not released after last bit");
  a_msb_coding: assert property (load |=> shreg_q[WORD_W-1] ==
    $past(head[WORD_W-1] ^ ~coding_sel)) // R15
    else $error("first bit coding wrong");
  a_slave_hold: assert property (state_q == ST_SLAVE && !upd_edge |=> $stable(shreg_q)) // R13
    else $error("slave data moved off the update edge");
  c_master_frame: cover property (master_end);
  c_slave_frame: cover property (slave_end);
  c_par_pop: cover property (par_pop);
  c_fifo_full: cover property (!result_ready);
endmodule : asp_serial_port
`default_nettype wire

//--- asp_host_model.sv
// Host model: reads result frames and clocks the port in slave use.
// Assumes the bench resolves the pins; everything is sampled on core_clk.
`timescale 1ns/1ps
`default_nettype none
module asp_host_model (
  input wire logic core_clk,
  input wire logic inv,
  input wire logic pol,
  input wire logic sclk_o,
  input wire logic sdo,
  input wire logic marker,
  output logic sclk_i,
  output logic chain_d,
  output logic [17:0] word,
  output var int frames,
  output var int bits,
  output var int per
);
  logic [17:0] sh;
  logic act_q;
  logic prev;
  int cnt;
  int last;
  wire act = marker ^ pol;
  wire rise = act && (sclk_o ^ inv) && !prev;

  initial begin
    sclk_i = 1'b0;
    chain_d = 1'b0;
  end

  always @(posedge core_clk) begin
    cnt <= cnt + 1;
    act_q <= act;
    prev <= sclk_o ^ inv;
    if (act && !act_q) bits <= 0;
    if (rise) begin
      sh <= {sh[16:0], sdo};
      bits <= bits + 1;
      per <= cnt - last;
      last <= cnt;
    end
    // Word latched at frame end, so a back-to-back frame cannot disturb it
    if (!act && act_q) begin
      word <= sh;
      frames <= frames + 1;
    end
  end

  task automatic run_slave(input int n, input logic [17:0] pat, output logic [35:0] got);
    for (int i = 0; i < n; i++) begin
      chain_d <= (i < 18) ? pat[17 - i] : ~chain_d;
      repeat (10) @(posedge core_clk);
      got = {got[34:0], sdo};
      sclk_i <= inv;
      repeat (10) @(posedge core_clk);
      sclk_i <= ~inv;
    end
  endtask : run_slave
endmodule : asp_host_model
`default_nettype wire

//--- asp_serial_port_test.sv
// Testbench: drives results, pins and registers; checks frames against a queue model.
// Assumes the host model reads frames and clocks the port in slave use.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module asp_serial_port_test;
  import asp_pkg::*;
  logic core_clk, nrst, result_valid, result_ready, conv_busy, output_coding_select;
  logic interface_select_low, interface_select_high, sclk_pin_o, sclk_pin_oe, sclk_in;
  logic serial_result_out, frame_marker, hsclk, hchain;
  logic [17:0] result_data, hword, lastw;
  logic [5:0] pdrv, drv, par_pin_i, par_pin_o, par_pin_oe;
  logic [3:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int hframes, hbits, hper, err_total, tests_run, cyc;
  logic [17:0] q[$];
  bit [31:0] seed = 12;
  assign drv = {pdrv[2] ? hchain : pdrv[5], pdrv[4:0]};
  assign par_pin_i = (par_pin_oe & par_pin_o) | (~par_pin_oe & drv);
  assign sclk_in = sclk_pin_oe ? sclk_pin_o : hsclk;

  asp_serial_port dut (.core_clk, .nrst, .result_data, .result_valid, .result_ready,
    .conv_busy, .interface_select_low, .interface_select_high, .output_coding_select,
    .par_pin_i, .par_pin_o, .par_pin_oe, .sclk_pin_i(sclk_in), .sclk_pin_o, .sclk_pin_oe,
    .serial_result_out, .frame_marker, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  asp_host_model host (.core_clk, .inv(pdrv[4]), .pol(pdrv[3]), .sclk_o(sclk_pin_o),
    .sdo(serial_result_out), .marker(frame_marker), .sclk_i(hsclk), .chain_d(hchain),
    .word(hword), .frames(hframes), .bits(hbits), .per(hper));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [17:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[17:0];
  endfunction : rnd

  function automatic logic [17:0] enc(input logic [17:0] w);
    return {w[17] ^ ~output_coding_select, w[16:0]};
  endfunction : enc

  task automatic summarize();
    $display("Counts: %0d checks, %0d mismatches", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  task automatic cfg(input logic [1:0] m, input logic [5:0] p, input logic c);
    @(posedge core_clk);
    {interface_select_high, interface_select_low} <= m;
    pdrv <= p;
    output_coding_select <= c;
    repeat (8) @(posedge core_clk);
  endtask : cfg

  task automatic push(input logic [17:0] w, output bit ok);
    @(posedge core_clk);
    result_data <= w;
    result_valid <= 1'b1;
    ok = 0;
    for (int n = 0; n < 12 && !ok; n++) begin
      @(posedge core_clk);
      ok = result_ready;
    end
    result_valid <= 1'b0;
    if (ok) q.push_back(enc(w));
  endtask : push

  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (int n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (int n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic frame(input int f0, input int pexp);
    for (int n = 0; n < 3000 && hframes == f0; n++) @(posedge core_clk);
    lastw = q.pop_front();
    `CHK("word", lastw, hword)
    `CHK("bits", 18, hbits)
    `CHK("period", pexp, hper)
  endtask : frame

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    logic [17:0] pat;
    logic [35:0] got;
    logic [31:0] d;
    logic [1:0] r;
    bit ok;
    int f0, k;
    {nrst, result_valid, conv_busy, interface_select_high, interface_select_low} = 5'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, result_data, pdrv} = '0;
    output_coding_select = 1'b1;
    repeat (10) @(posedge core_clk);
    `CHK("oe_rst", 6'h00, par_pin_oe)
    nrst <= 1'b1;
    rd(ASP_ADDR_CTRL, d, r);
    `CHK("ctrl_rst", ASP_CTRL_RESET, d)
    rd(4'hC, d, r);
    `CHK("rd_unmapped", {ASP_RESP_SLVERR, 32'h0}, {r, d})
    wr(4'hC, 32'h0, r);
    `CHK("wr_unmapped", ASP_RESP_SLVERR, r)
    wr(ASP_ADDR_STATUS, 32'hFFFF_FFFF, r);
    `CHK("wr_status", ASP_RESP_OKAY, r)
    $display("registers end");
    // parallel modes drive bits 4 to 9
    for (k = 0; k < 3; k++) begin
      cfg(k[1:0], 6'h00, 1'b1);
      pat = rnd();
      push(pat, ok);
      repeat (6) @(posedge core_clk);
      `CHK("par_oe", 6'h3F, par_pin_oe)
      `CHK("par_bits", pat[9:4], par_pin_o)
    end
    q.delete();
    $display("parallel end");
    // master runs during conversion whatever the divide pins say
    conv_busy <= 1'b1;
    for (k = 0; k < 8; k++) begin
      cfg(ASP_MODE_SERIAL, {1'b1, k[2], k[1], 1'b0, k[1:0]}, k[0]);
      f0 = hframes;
      push(rnd(), ok);
      frame(f0, 4);
      `CHK("sclk_oe", 1'b1, sclk_pin_oe)
      `CHK("mark_idle", pdrv[3], frame_marker)
      `CHK("sclk_idle", pdrv[4], sclk_pin_o)
    end
    rd(ASP_ADDR_LAST, d, r);
    `CHK("last", lastw, d[17:0])
    // after-convert frames wait for the conversion, clock divided
    for (k = 0; k < 4; k++) begin
      cfg(ASP_MODE_SERIAL, {4'h0, k[1:0]}, 1'b1);
      f0 = hframes;
      push(rnd(), ok);
      repeat (60) @(posedge core_clk);
      `CHK("held", f0, hframes)
      conv_busy <= 1'b0;
      frame(f0, 4 << k);
      conv_busy <= 1'b1;
    end
    $display("master end");
    // Fill the buffer while the port is off, then drain in order
    conv_busy <= 1'b0;
    wr(ASP_ADDR_CTRL, 32'h0, r);
    cfg(ASP_MODE_SERIAL, 6'h20, 1'b0);
    k = 0;
    for (int i = 0; i < 10; i++) begin
      push(rnd(), ok);
      k += ok;
    end
    `CHK("taken", ASP_FIFO_DEPTH, k)
    rd(ASP_ADDR_STATUS, d, r);
    `CHK("level", 4'h8, d[ASP_ST_LEVEL_LSB +: 4])
    wr(ASP_ADDR_CTRL, 32'h1, r);
    for (k = 0; k < 8; k++) frame(hframes, 4);
    $display("buffer end");
    wr(ASP_ADDR_CTRL, 32'h11, r);
    cfg(ASP_MODE_SERIAL, 6'h14, 1'b1);
    push(rnd(), ok);
    pat = rnd();
    repeat (10) @(posedge core_clk);
    host.run_slave(36, pat, got);
    lastw = q.pop_front();
    `CHK("chain", {lastw, pat}, got)
    `CHK("sclk_oe_ext", 1'b0, sclk_pin_oe)
    $display("slave end");
    summarize();
  end
endmodule : asp_serial_port_test
`default_nettype wire
